// >>> hw/csr_pkg.sv
// Purpose: constants and types for the clock source routing block
// Assumes: 32-bit apb, each register one word at four times its index
// Notes: defaults below are what reset and power-up leave active
// Operation
// - power-up: pll off, clk through divider
// - power field 01b holds pll powered down
// - power field 00b runs pll normally
// - divider ratio field defaults 010b, divide four
// - divider path never divides below two
// - bypass bit 0 feeds distribution from divider
// - source bit 0 selects external clk input
// - polarity bit sets phase detector sense
// - settings apply only on update write 01h
// - pll on with clk: vco off, clk to prescaler
// - reset restores defaults; software may rewrite them
package csr_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] CSR_IDX_PLL_PWR  = 10'h010;
  localparam logic [9:0] CSR_IDX_VCO_DIV  = 10'h1e0;
  localparam logic [9:0] CSR_IDX_ROUTING  = 10'h1e1;
  localparam logic [9:0] CSR_IDX_UPDATE   = 10'h232;
  // field positions
  localparam int CSR_POL_BIT    = 7;
  localparam int CSR_BYPASS_BIT = 0;
  localparam int CSR_SRCSEL_BIT = 1;
  // field values
  localparam logic [1:0] CSR_PWR_NORMAL = 2'h0;
  localparam logic [1:0] CSR_PWR_ASYNC  = 2'h1;
  localparam logic [2:0] CSR_DIV_MAX    = 3'h4;
  localparam logic [2:0] CSR_RATIO_MIN  = 3'h2;
  localparam logic [2:0] CSR_RATIO_MAX  = 3'h6;
  localparam logic [7:0] CSR_UPDATE_KEY = 8'h01;
  // reset values
  localparam logic       CSR_RST_POL    = 1'h0;
  localparam logic [2:0] CSR_RST_DIV    = 3'h2;
  localparam logic       CSR_RST_BYPASS = 1'h0;
  localparam logic       CSR_RST_SRCSEL = 1'h0;
  // one set of routing settings
  typedef struct packed {
    logic       pol;     // 1: negative pfd polarity
    logic [1:0] pwr;     // pll power mode
    logic [2:0] div;     // vco divider code
    logic       bypass;  // 1: skip the vco divider
    logic       srcsel;  // 1: internal vco, 0: clk input
  } csr_cfg_t;
  localparam csr_cfg_t CSR_CFG_RST = '{pol: CSR_RST_POL, pwr: CSR_PWR_ASYNC,
    div: CSR_RST_DIV, bypass: CSR_RST_BYPASS, srcsel: CSR_RST_SRCSEL};
endpackage

// >>> hw/csr_routing.sv
// Purpose: staged pll power, vco divider and source routing controls
// Assumes: apb master on clock_in; update key commits all settings
// Notes: every output is a flop; reads show staged values
`timescale 1ns/10ps
`default_nettype none
module csr_routing
  import csr_pkg::*;
(
  input  wire logic        clock_in,             // 40 mhz system clock
  input  wire logic        sys_rst_in,           // async reset, high
  input  wire logic        psel_in,              // apb select
  input  wire logic        penable_in,           // apb access phase
  input  wire logic        pwrite_in,            // apb direction
  input  wire logic [11:0] paddr_in,             // apb byte address
  input  wire logic [31:0] pwdata_in,            // apb write data
  output logic      [31:0] prdata_out,           // apb read data
  output logic             pready_out,           // apb ready
  output logic             pslverr_out,          // apb error, unmapped
  output logic             pll_enable_out,       // pll running
  output logic             pll_async_pd_out,     // pll async power-down
  output logic             pfd_neg_pol_out,      // negative pfd sense
  output logic      [2:0]  vco_div_ratio_out,    // applied ratio 2..6
  output logic             dist_from_div_out,    // dist fed by divider
  output logic             src_vco_out,          // vco is the source
  output logic             int_vco_pwr_out,      // internal vco powered
  output logic             ext_to_prescaler_out, // clk input to prescaler
  output csr_cfg_t         active_cfg_out        // committed settings
);

  // staged settings written by software
  csr_cfg_t   stage;
  // apb decode
  logic [9:0] idx;          // register index
  logic       access;       // access phase, not yet answered
  logic       done;         // transfer completes this edge
  logic       wr_done;      // write completes this edge
  logic       mapped;       // index hits a register
  logic       upd_fire;     // commit of staged settings
  logic [31:0] next_rdata;  // read mux
  logic [2:0] next_ratio;   // decoded divider ratio

  assign idx     = paddr_in[11:2];
  assign access  = psel_in && penable_in && !pready_out;
  assign done    = psel_in && penable_in && pready_out;
  assign wr_done = done && pwrite_in;
  assign mapped  = (idx == CSR_IDX_PLL_PWR) || (idx == CSR_IDX_VCO_DIV) ||
                   (idx == CSR_IDX_ROUTING) || (idx == CSR_IDX_UPDATE);
  // only the exact key commits
  assign upd_fire = wr_done && (idx == CSR_IDX_UPDATE) &&
                    (pwdata_in[7:0] == CSR_UPDATE_KEY);

  // ready one cycle into the access phase, dropped after completion
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= access;
      pslverr_out <= access && !mapped;
    end
  end

  // read mux: staged fields, reserved bits zero, update reads zero
  always_comb begin
    next_rdata = '0;
    unique case (idx)
      CSR_IDX_PLL_PWR: begin
        next_rdata[CSR_POL_BIT] = stage.pol;
        next_rdata[1:0]         = stage.pwr;
      end
      CSR_IDX_VCO_DIV: begin
        next_rdata[2:0] = stage.div;
      end
      CSR_IDX_ROUTING: begin
        next_rdata[CSR_BYPASS_BIT] = stage.bypass;
        next_rdata[CSR_SRCSEL_BIT] = stage.srcsel;
      end
      default: begin
        next_rdata = '0;  // update and unmapped read zero
      end
    endcase
  end

  // read data captured with ready
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prdata_out <= '0;
    end else if (access && !pwrite_in) begin
      prdata_out <= next_rdata;
    end
  end

  // staging writes, taken only at the completing edge
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage <= CSR_CFG_RST;
    end else if (wr_done) begin
      if (idx == CSR_IDX_PLL_PWR) begin
        stage.pol <= pwdata_in[CSR_POL_BIT];
        stage.pwr <= pwdata_in[1:0];
      end
      if (idx == CSR_IDX_VCO_DIV) begin
        stage.div <= pwdata_in[2:0];
      end
      if (idx == CSR_IDX_ROUTING) begin
        stage.bypass <= pwdata_in[CSR_BYPASS_BIT];
        stage.srcsel <= pwdata_in[CSR_SRCSEL_BIT];
      end
    end
  end

  // divider code to ratio; codes past the top clamp to the largest
  always_comb begin
    if (stage.div > CSR_DIV_MAX) begin
      next_ratio = CSR_RATIO_MAX;
    end else begin
      next_ratio = stage.div + CSR_RATIO_MIN;
    end
  end

  // active set: defaults from reset, whole set copied on commit
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      active_cfg_out <= CSR_CFG_RST;
    end else if (upd_fire) begin
      active_cfg_out <= stage;
    end
  end

  // decoded controls, also changed only on commit
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pll_enable_out       <= 1'b0;
      pll_async_pd_out     <= 1'b1;
      pfd_neg_pol_out      <= CSR_RST_POL;
      vco_div_ratio_out    <= CSR_RST_DIV + CSR_RATIO_MIN;
      dist_from_div_out    <= !CSR_RST_BYPASS;
      src_vco_out          <= CSR_RST_SRCSEL;
      int_vco_pwr_out      <= 1'b0;
      ext_to_prescaler_out <= 1'b0;
    end else if (upd_fire) begin
      // pll runs only on the normal code
      pll_enable_out    <= (stage.pwr == CSR_PWR_NORMAL);
      // async code holds the pll down
      pll_async_pd_out  <= (stage.pwr == CSR_PWR_ASYNC);
      pfd_neg_pol_out   <= stage.pol;
      vco_div_ratio_out <= next_ratio;
      dist_from_div_out <= !stage.bypass;
      src_vco_out       <= stage.srcsel;
      // vco powered only when it is the source of a running pll
      int_vco_pwr_out   <= (stage.pwr == CSR_PWR_NORMAL) && stage.srcsel;
      // running pll on clk input: clk goes straight to the prescaler
      ext_to_prescaler_out <= (stage.pwr == CSR_PWR_NORMAL) &&
                              !stage.srcsel;
    end
  end

  // checks on the commit path
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  // commit with given staged fields
  sequence s_commit_pwr(logic [1:0] p);
    upd_fire && (stage.pwr == p);
  endsequence
  sequence s_commit_src(logic s);
    upd_fire && (stage.srcsel == s);
  endsequence

  reset_defaults_a: assert property ($fell(sys_rst_in) |->
    !pll_enable_out && pll_async_pd_out && dist_from_div_out && !src_vco_out)
    else $error("defaults not in force after reset");
  async_pd_a: assert property (s_commit_pwr(CSR_PWR_ASYNC) |=>
    pll_async_pd_out && !pll_enable_out)
    else $error("async power code did not power pll down");
  normal_run_a: assert property (s_commit_pwr(CSR_PWR_NORMAL) |=>
    pll_enable_out && !pll_async_pd_out)
    else $error("normal code did not run pll");
  div_four_a: assert property (upd_fire && stage.div == CSR_RST_DIV |=>
    vco_div_ratio_out == 3'h4)
    else $error("code 010b did not give divide by four");
  min_ratio_a: assert property (vco_div_ratio_out >= CSR_RATIO_MIN &&
    vco_div_ratio_out <= CSR_RATIO_MAX)
    else $error("divider ratio out of range");
  bypass_sel_a: assert property (upd_fire |=>
    dist_from_div_out == !$past(stage.bypass))
    else $error("bypass bit not applied");
  clk_source_a: assert property (s_commit_src(1'b0) |=> !src_vco_out)
    else $error("clk input not selected");
  polarity_a: assert property (upd_fire |=>
    pfd_neg_pol_out == $past(stage.pol))
    else $error("polarity not applied");
  hold_active_a: assert property (!upd_fire |=>
    $stable(active_cfg_out) && $stable(pll_enable_out))
    else $error("settings changed without commit");
  commit_all_a: assert property (upd_fire |=>
    active_cfg_out == $past(stage))
    else $error("staged set not copied whole");
  ext_path_a: assert property (s_commit_pwr(CSR_PWR_NORMAL) ##0
    s_commit_src(1'b0) |=> ext_to_prescaler_out && !int_vco_pwr_out)
    else $error("clk input not routed to prescaler");
  apb_answer_a: assert property (psel_in && penable_in && !pready_out |=>
    pready_out ##1 !pready_out)
    else $error("apb answer not one cycle after access");

  // completed write aimed at one register index
  sequence s_write_idx(logic [9:0] r);
    wr_done && (idx == r);
  endsequence
  // read access phase aimed at one register index
  sequence s_read_idx(logic [9:0] r);
    access && !pwrite_in && (idx == r);
  endsequence
  // update write that carries anything but the key
  sequence s_bad_key;
    wr_done && (idx == CSR_IDX_UPDATE) && (pwdata_in[7:0] != CSR_UPDATE_KEY);
  endsequence

  // ready is a pulse; a stuck ready would swallow the next transfer
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("pready held longer than one cycle");
  // the error flag only rides on the answer cycle
  err_with_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  // unmapped index answers with an error
  unmapped_err_a: assert property (access && !mapped |=> pslverr_out)
    else $error("unmapped access gave no error");
  // mapped index answers cleanly
  mapped_ok_a: assert property (access && mapped |=> !pslverr_out)
    else $error("mapped access flagged an error");

  // staged power and polarity follow the written word
  stage_pwr_a: assert property (s_write_idx(CSR_IDX_PLL_PWR) |=>
    stage.pwr == $past(pwdata_in[1:0]) && stage.pol == $past(pwdata_in[CSR_POL_BIT]))
    else $error("power register not staged");
  // staged divider code follows the written word
  stage_div_a: assert property (s_write_idx(CSR_IDX_VCO_DIV) |=>
    stage.div == $past(pwdata_in[2:0]))
    else $error("divider register not staged");
  // staged routing bits follow the written word
  stage_route_a: assert property (s_write_idx(CSR_IDX_ROUTING) |=>
    stage.bypass == $past(pwdata_in[CSR_BYPASS_BIT]) &&
    stage.srcsel == $past(pwdata_in[CSR_SRCSEL_BIT]))
    else $error("routing register not staged");
  // staging only moves on a completed write
  stage_hold_a: assert property (!wr_done |=> $stable(stage))
    else $error("staged set changed without a write");

  // reads of the power register show staged fields
  read_pwr_a: assert property (s_read_idx(CSR_IDX_PLL_PWR) |=>
    prdata_out[1:0] == stage.pwr && prdata_out[CSR_POL_BIT] == stage.pol)
    else $error("power register read wrong");
  // the update register always reads zero
  read_upd_a: assert property (s_read_idx(CSR_IDX_UPDATE) |=> prdata_out == '0)
    else $error("update register read not zero");

  // a wrong key leaves everything applied untouched
  bad_key_a: assert property (s_bad_key |=>
    $stable(active_cfg_out) && $stable(src_vco_out) && $stable(pll_async_pd_out))
    else $error("wrong update key changed settings");

  // decoded outputs always agree with the committed set
  pll_match_a: assert property (
    pll_enable_out == (active_cfg_out.pwr == CSR_PWR_NORMAL))
    else $error("pll enable disagrees with committed power");
  apd_match_a: assert property (
    pll_async_pd_out == (active_cfg_out.pwr == CSR_PWR_ASYNC))
    else $error("power-down disagrees with committed power");
  pol_match_a: assert property (pfd_neg_pol_out == active_cfg_out.pol)
    else $error("polarity disagrees with committed set");
  dist_match_a: assert property (dist_from_div_out == !active_cfg_out.bypass)
    else $error("distribution feed disagrees with committed set");
  src_match_a: assert property (src_vco_out == active_cfg_out.srcsel)
    else $error("source select disagrees with committed set");
  // power codes are exclusive: never running and held down at once
  power_excl_a: assert property (!(pll_enable_out && pll_async_pd_out))
    else $error("pll both running and powered down");

  // clk input into the prescaler means the vco is dark
  ext_vco_off_a: assert property (ext_to_prescaler_out |->
    !int_vco_pwr_out && !src_vco_out && pll_enable_out)
    else $error("vco powered while clk feeds prescaler");
  // with the pll off neither pll path is live
  pll_off_paths_a: assert property (!pll_enable_out |->
    !int_vco_pwr_out && !ext_to_prescaler_out)
    else $error("pll path live with pll off");
  // codes past the top clamp to the largest ratio
  ratio_clamp_a: assert property (upd_fire && stage.div > CSR_DIV_MAX |=>
    vco_div_ratio_out == CSR_RATIO_MAX)
    else $error("large divider code not clamped");

endmodule // csr_routing
`default_nettype wire

// >>> tb/csr_routing_tb_top.sv
// Purpose: self-checking bench for the staged clock source routing block
// Assumes: apb answers with one wait state; commit shows one cycle after update
// Notes: expected settings are derived here from the field meanings
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module csr_routing_tb_top;
  import csr_pkg::*;
  logic        clock_in, sys_rst_in, psel, penable, pwrite;  // bench driven controls
  logic [11:0] paddr;                                        // byte address
  logic [31:0] pwdata, prdata, rd;                           // write data, read data
  logic        pready, pslverr, err;                         // answer signals
  logic        pll_en, apd, neg_pol, dist_div, src_vco, vco_pwr, ext_pre;
  logic [2:0]  ratio;                                        // applied divide ratio
  csr_cfg_t    act;                                          // committed settings
  int          error_cnt = 0;                                // mismatches seen
  int          check_count = 0;                              // comparisons made
  localparam logic [11:0] A_PWR = {CSR_IDX_PLL_PWR, 2'h0};  // byte addresses
  localparam logic [11:0] A_DIV = {CSR_IDX_VCO_DIV, 2'h0};
  localparam logic [11:0] A_RTE = {CSR_IDX_ROUTING, 2'h0};
  localparam logic [11:0] A_UPD = {CSR_IDX_UPDATE, 2'h0};
  csr_routing dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .pll_enable_out(pll_en), .pll_async_pd_out(apd), .pfd_neg_pol_out(neg_pol),
    .vco_div_ratio_out(ratio), .dist_from_div_out(dist_div), .src_vco_out(src_vco),
    .int_vco_pwr_out(vco_pwr), .ext_to_prescaler_out(ext_pre), .active_cfg_out(act));
  // 40 mhz clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // verdict and end of run
  task automatic finish_test;
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clock_in);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_in);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      finish_test();
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // read and compare one word
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK("rdata", e, rd)
    `CHK("slverr", ee, err)
  endtask
  // write key byte k to the update register and wait a cycle for any commit to show
  task automatic commit(input logic [7:0] k);
    apb(1'b1, A_UPD, {24'h0, k});
    @(posedge clock_in);
    #1;
  endtask
  // compare committed set and every decoded output against the expectation
  task automatic chk(input csr_cfg_t c);
    logic on;
    on = (c.pwr == CSR_PWR_NORMAL);
    `CHK("active", c, act)
    `CHK("pll_en", on, pll_en)
    `CHK("async_pd", (c.pwr == CSR_PWR_ASYNC), apd)
    `CHK("neg_pol", c.pol, neg_pol)
    `CHK("ratio", ((c.div > 3'h4) ? 3'h6 : c.div + 3'h2), ratio)
    `CHK("dist_div", ~c.bypass, dist_div)
    `CHK("src_vco", c.srcsel, src_vco)
    `CHK("vco_pwr", on & c.srcsel, vco_pwr)
    `CHK("ext_pre", on & ~c.srcsel, ext_pre)
  endtask
  // main sequence
  initial begin
    int k;
    sys_rst_in = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0;
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    #1;
    chk(CSR_CFG_RST);
    rchk(A_PWR, 32'h01, 1'b0);
    rchk(A_DIV, 32'h02, 1'b0);
    rchk(A_RTE, 32'h00, 1'b0);
    apb(1'b1, A_PWR, 32'h80);
    apb(1'b1, A_RTE, 32'hff);
    rchk(A_RTE, 32'h03, 1'b0);
    rchk(A_PWR, 32'h80, 1'b0);
    #1;
    chk(CSR_CFG_RST);
    commit(8'h02);
    chk(CSR_CFG_RST);
    commit(8'h01);
    chk('{pol: 1'b1, pwr: 2'h0, div: 3'h2, bypass: 1'b1, srcsel: 1'b1});
    rchk(A_UPD, 32'h00, 1'b0);
    apb(1'b1, A_RTE, 32'h00);
    commit(8'h01);
    chk('{pol: 1'b1, pwr: 2'h0, div: 3'h2, bypass: 1'b0, srcsel: 1'b0});
    // every divider code, applied only through the update write
    for (k = 0; k < 8; k++) begin
      apb(1'b1, A_DIV, k);
      commit(8'h01);
      chk('{pol: 1'b1, pwr: 2'h0, div: k[2:0], bypass: 1'b0, srcsel: 1'b0});
    end
    rchk(12'h000, 32'h0, 1'b1);
    apb(1'b1, 12'h000, 32'hff);
    `CHK("wr_slverr", 1'b1, err)
    // software puts the defaults back by hand
    apb(1'b1, A_PWR, 32'h01);
    apb(1'b1, A_DIV, 32'h02);
    commit(8'h01);
    chk(CSR_CFG_RST);
    apb(1'b1, A_PWR, 32'h00);
    commit(8'h01);
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    #1;
    chk(CSR_CFG_RST);
    rchk(A_PWR, 32'h01, 1'b0);
    finish_test();
  end
endmodule // csr_routing_tb_top
`default_nettype wire
